// ### pmwg_shadow_bank.sv
// Constants of the program memory write guard, and the configuration
// shadow bank that holds the live guard bits beside their complement.
// Assumes one clock, a synchronous active-high reset, and loads that come
// from the bus side of the guard on the same clock.
//
// Operation
// - Read guard active: refuse external reads and writes; execution reads still pass.
// - Write guard at 0: block every internal write and erase.
// - Segment active: any write or erase inside the segment is blocked.
// - Segment only adds protection; global guards still apply outside it.
// - Segment active only when disable bit is 0; otherwise segment bits ignored.
// - Eight-bit page field picks a 512-word page, always inside the segment.
// - Direction 0: protect address zero through end of selected page.
// - Direction 1: protect selected page through end of memory, ignoring last-page bit.
// - Bottom segment with last-page bit 0 also protects the final page.
// - Complement shadow of configuration kept and compared continuously.
// - Corrupted configuration bit flags parity error and issues device reset.
// - Configuration loaded from stored configuration words; read guard covers them. Here loaded by Wishbone writes to OFS_CFG; readback ignores read guard.

`timescale 1ns/1ps
`default_nettype none

package pmwg_pkg;

  // =========================================================================
  // Memory geometry
  localparam int unsigned ADDR_W    = 17;
  localparam int unsigned PAGE_W    = 8;
  localparam int unsigned PAGE_LSB  = 9;   // 512 words per page
  localparam logic [7:0]  LAST_PAGE = 8'hff;

  // =========================================================================
  // Configuration word layout
  localparam int unsigned CFG_W     = 13;
  localparam int unsigned FP_LSB    = 0;
  localparam int unsigned FP_MSB    = 7;
  localparam int unsigned DIR_BIT   = 8;
  localparam int unsigned LPG_BIT   = 9;
  localparam int unsigned DIS_BIT   = 10;
  localparam int unsigned WG_BIT    = 11;
  localparam int unsigned RG_BIT    = 12;
  localparam logic [12:0] CFG_RST   = 13'h0fff;  // Unprogrammed, read guard off

  // =========================================================================
  // Request kinds
  localparam logic [1:0]  KIND_READ  = 2'h0;
  localparam logic [1:0]  KIND_WRITE = 2'h1;
  localparam logic [1:0]  KIND_ERASE = 2'h2;

  // =========================================================================
  // Register map
  localparam int unsigned WB_ADR_W  = 8;
  localparam logic [7:0]  OFS_CFG    = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_INJECT = 8'h08;
  localparam int unsigned ST_FAULT   = 0;
  localparam int unsigned ST_LDENY   = 1;
  localparam int unsigned ST_CNT_LSB = 8;
  localparam int unsigned ST_SEGACT  = 16;
  localparam logic [7:0]  CNT_MAX    = 8'hff;

  // =========================================================================
  // Segment decode: true when a page lies in the protected segment
  function automatic logic seg_hit(input logic [CFG_W-1:0] cfg, input logic [PAGE_W-1:0] page);
    logic [PAGE_W-1:0] sel;
    logic              hit;
    sel = cfg[FP_MSB:FP_LSB];
    hit = 1'b0;
    if (!cfg[DIS_BIT]) begin
      if (cfg[DIR_BIT]) begin
        hit = (page >= sel);
      end else begin
        hit = (page <= sel) || (!cfg[LPG_BIT] && (page == LAST_PAGE));
      end
    end
    return hit;
  endfunction

endpackage

module pmwg_shadow_bank (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     load_i,
  input  wire logic [pmwg_pkg::CFG_W-1:0] load_data_i,
  input  wire logic [pmwg_pkg::CFG_W-1:0] flip_i,
  output logic      [pmwg_pkg::CFG_W-1:0] cfg_o,
  output logic                          mismatch_o,
  output logic                          parity_err_o
);

  typedef struct packed {
    logic [pmwg_pkg::CFG_W-1:0] live;
    logic [pmwg_pkg::CFG_W-1:0] shadow;
    logic                       par;
    logic [pmwg_pkg::CFG_W-1:0] cfg;
    logic                       mis;
    logic                       perr;
  } pmwg_bank_s;

  pmwg_bank_s st_reg;
  pmwg_bank_s st_next;

  // =========================================================================
  // Next state: load, cell upsets, compare
  always_comb begin
    st_next = st_reg;
    if (load_i) begin
      st_next.live   = load_data_i;
      st_next.shadow = ~load_data_i;
      st_next.par    = ^load_data_i;
    end else begin
      st_next.live   = st_reg.live ^ flip_i;  // Cell upset hits live copy only
    end
    st_next.cfg  = st_reg.live;
    st_next.mis  = (st_reg.live != ~st_reg.shadow);
    st_next.perr = ((^st_reg.live) != st_reg.par);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '{live: pmwg_pkg::CFG_RST, shadow: ~pmwg_pkg::CFG_RST, par: ^pmwg_pkg::CFG_RST,
                  cfg: pmwg_pkg::CFG_RST, mis: 1'b0, perr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_o        = st_reg.cfg;
  assign mismatch_o   = st_reg.mis;
  assign parity_err_o = st_reg.perr;

endmodule

`default_nettype wire

// ### pmwg_guard.sv
// Program memory write guard: decides each read, write and erase request
// from the flash sequencer or the external programming port, and holds the
// guard configuration behind a classic Wishbone slave.
// Assumes requests on the same clock as the bus, one request per cycle at most.

`timescale 1ns/1ps
`default_nettype none

module pmwg_guard (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [pmwg_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Memory access requests
  input  wire logic                          req_valid_i,
  input  wire logic                          req_ext_i,
  input  wire logic [1:0]                    req_kind_i,
  input  wire logic [pmwg_pkg::ADDR_W-1:0]   req_addr_i,
  output logic                               req_grant_o,
  output logic                               req_deny_o,
  // Device reset on configuration fault
  output logic                               dev_reset_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        grant;
    logic        deny;
    logic        dev_reset;
    logic        fault_prev;
    logic        fault;
    logic        last_deny;
    logic [7:0]  deny_cnt;
    logic [pmwg_pkg::CFG_W-1:0] inject;
  } pmwg_guard_s;

  pmwg_guard_s st_reg;
  pmwg_guard_s st_next;

  logic [pmwg_pkg::CFG_W-1:0]  cfg_w;
  logic                        mis_w;
  logic                        perr_w;
  logic                        access_w;
  logic                        wr_fire_w;
  logic                        low_lanes_w;
  logic                        load_w;
  logic                        fault_now_w;
  logic [pmwg_pkg::PAGE_W-1:0] req_page_w;
  logic                        seg_act_w;

  // =========================================================================
  // Bus decode
  assign access_w    = wb_cyc_i & wb_stb_i;
  assign wr_fire_w   = access_w & wb_we_i & st_reg.ack;  // Write lands on the ack edge
  assign low_lanes_w = (wb_sel_i[1:0] == 2'h3);
  assign load_w      = wr_fire_w & low_lanes_w & (wb_adr_i == pmwg_pkg::OFS_CFG);
  assign fault_now_w = mis_w | perr_w;
  assign req_page_w  = req_addr_i[pmwg_pkg::ADDR_W-1:pmwg_pkg::PAGE_LSB];
  assign seg_act_w   = ~cfg_w[pmwg_pkg::DIS_BIT];

  // =========================================================================
  // Configuration image with complement shadow
  pmwg_shadow_bank u_bank (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .load_i       (load_w),
    .load_data_i  (wb_dat_i[pmwg_pkg::CFG_W-1:0]),
    .flip_i       (st_reg.inject),
    .cfg_o        (cfg_w),
    .mismatch_o   (mis_w),
    .parity_err_o (perr_w)
  );

  // =========================================================================
  // Access decision for one request
  function automatic logic deny_of(input logic [pmwg_pkg::CFG_W-1:0]  cfg,
                                   input logic                        ext,
                                   input logic [1:0]                  kind,
                                   input logic [pmwg_pkg::PAGE_W-1:0] page);
    logic d;
    d = 1'b0;
    if (kind == pmwg_pkg::KIND_READ) begin
      d = ext & cfg[pmwg_pkg::RG_BIT];
    end else if ((kind == pmwg_pkg::KIND_WRITE) || (kind == pmwg_pkg::KIND_ERASE)) begin
      d = (ext & cfg[pmwg_pkg::RG_BIT])
        | (~ext & ~cfg[pmwg_pkg::WG_BIT])
        | pmwg_pkg::seg_hit(cfg, page);
    end else begin
      d = 1'b1;  // Unknown kind never granted
    end
    return d;
  endfunction

  // =========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    // Single-cycle ack, dropped the cycle after it is given
    st_next.ack = access_w & ~st_reg.ack;
    st_next.dat = 32'h0;
    if (access_w & ~st_reg.ack & ~wb_we_i) begin
      unique case (wb_adr_i)
        pmwg_pkg::OFS_CFG:    st_next.dat = {19'h0, cfg_w};
        pmwg_pkg::OFS_STATUS: st_next.dat = {15'h0, seg_act_w, st_reg.deny_cnt, 6'h0,
                                             st_reg.last_deny, st_reg.fault};
        default:              st_next.dat = 32'h0;
      endcase
    end
    // Fault injection pulse toward the bank
    st_next.inject = '0;
    if (wr_fire_w & low_lanes_w & (wb_adr_i == pmwg_pkg::OFS_INJECT)) begin
      st_next.inject = wb_dat_i[pmwg_pkg::CFG_W-1:0];
    end
    // Request decision, blocked requests never granted
    st_next.grant = 1'b0;
    st_next.deny  = 1'b0;
    if (req_valid_i) begin
      st_next.deny      = deny_of(cfg_w, req_ext_i, req_kind_i, req_page_w);
      st_next.grant     = ~st_next.deny;
      st_next.last_deny = st_next.deny;
      if (st_next.deny && (st_reg.deny_cnt != pmwg_pkg::CNT_MAX)) begin
        st_next.deny_cnt = st_reg.deny_cnt + 8'h01;
      end
    end
    // Fault: reset pulse on each new fault, sticky flag with set winning
    st_next.fault_prev = fault_now_w;
    st_next.dev_reset  = fault_now_w & ~st_reg.fault_prev;
    if (wr_fire_w & wb_sel_i[0] & (wb_adr_i == pmwg_pkg::OFS_STATUS) & wb_dat_i[pmwg_pkg::ST_FAULT]) begin
      st_next.fault = 1'b0;
    end
    if (fault_now_w) begin
      st_next.fault = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // =========================================================================
  // Outputs
  assign wb_ack_o    = st_reg.ack;
  assign wb_dat_o    = st_reg.dat;
  assign req_grant_o = st_reg.grant;
  assign req_deny_o  = st_reg.deny;
  assign dev_reset_o = st_reg.dev_reset;

  // =========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Request shapes
  sequence s_ext_rd_guarded;
    req_valid_i && req_ext_i && (req_kind_i == pmwg_pkg::KIND_READ) && cfg_w[pmwg_pkg::RG_BIT];
  endsequence

  sequence s_modify;
    req_valid_i && ((req_kind_i == pmwg_pkg::KIND_WRITE) || (req_kind_i == pmwg_pkg::KIND_ERASE));
  endsequence

  sequence s_refused;
    req_deny_o && !req_grant_o;
  endsequence

  sequence s_granted;
    req_grant_o && !req_deny_o;
  endsequence

  a_ext_read_block: assert property (s_ext_rd_guarded |=> s_refused)
    else $error("external read passed the read guard");

  a_exec_read_pass: assert property (req_valid_i && !req_ext_i && (req_kind_i == pmwg_pkg::KIND_READ)
                                     |=> s_granted)
    else $error("execution read was refused");

  a_write_guard_block: assert property (s_modify ##0 (!req_ext_i && !cfg_w[pmwg_pkg::WG_BIT])
                                        |=> s_refused)
    else $error("internal write passed the write guard");

  a_segment_block: assert property (s_modify ##0 pmwg_pkg::seg_hit(cfg_w, req_page_w)
                                    |=> s_refused)
    else $error("write inside segment was granted");

  a_global_kept: assert property (s_modify ##0 (req_ext_i && cfg_w[pmwg_pkg::RG_BIT]
                                  && !pmwg_pkg::seg_hit(cfg_w, req_page_w)) |=> s_refused)
    else $error("segment setting relaxed the read guard");

  a_disable_ignores: assert property (s_modify ##0 (!req_ext_i && cfg_w[pmwg_pkg::WG_BIT]
                                      && cfg_w[pmwg_pkg::DIS_BIT]) |=> s_granted)
    else $error("disabled segment still blocked a write");

  a_page_inclusive: assert property (s_modify ##0 (!cfg_w[pmwg_pkg::DIS_BIT]
                                     && (req_page_w == cfg_w[pmwg_pkg::FP_MSB:pmwg_pkg::FP_LSB]))
                                     |=> s_refused)
    else $error("selected page itself was not protected");

  a_bottom_edge: assert property (s_modify ##0 (!req_ext_i && cfg_w[pmwg_pkg::WG_BIT]
                                  && !cfg_w[pmwg_pkg::DIS_BIT] && !cfg_w[pmwg_pkg::DIR_BIT]
                                  && cfg_w[pmwg_pkg::LPG_BIT]
                                  && (req_page_w > cfg_w[pmwg_pkg::FP_MSB:pmwg_pkg::FP_LSB]))
                                  |=> s_granted)
    else $error("page above bottom segment was blocked");

  a_top_segment: assert property (s_modify ##0 (!cfg_w[pmwg_pkg::DIS_BIT] && cfg_w[pmwg_pkg::DIR_BIT]
                                  && (req_page_w == pmwg_pkg::LAST_PAGE)) |=> s_refused)
    else $error("top segment left the last page open");

  a_last_page: assert property (s_modify ##0 (!cfg_w[pmwg_pkg::DIS_BIT] && !cfg_w[pmwg_pkg::DIR_BIT]
                                && !cfg_w[pmwg_pkg::LPG_BIT] && (req_page_w == pmwg_pkg::LAST_PAGE))
                                |=> s_refused)
    else $error("last page unguarded with bottom segment");

  a_shadow_detect: assert property ((wr_fire_w && low_lanes_w && (wb_adr_i == pmwg_pkg::OFS_INJECT)
                                     && (wb_dat_i[pmwg_pkg::CFG_W-1:0] != '0)) |-> ##[1:4] mis_w)
    else $error("shadow compare missed a corrupted bit");

  a_fault_reset: assert property ($rose(fault_now_w) |=> dev_reset_o ##1 !dev_reset_o)
    else $error("configuration fault gave no reset pulse");

  a_cfg_load: assert property (load_w |=> ##1 (cfg_w == $past(wb_dat_i[pmwg_pkg::CFG_W-1:0], 2)))
    else $error("configuration word not loaded");

  a_blocked_no_grant: assert property (req_deny_o |-> !req_grant_o)
    else $error("request both granted and denied");

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // =========================================================================
  // Handshake and status assertions
  // Bus request still waiting for its answer
  sequence s_bus_wait;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // Neither verdict on the request port
  sequence s_no_answer;
    !req_grant_o && !req_deny_o;
  endsequence

  // Illegal request kind, neither read nor modify
  sequence s_odd_kind;
    req_valid_i && (req_kind_i != pmwg_pkg::KIND_READ)
    && (req_kind_i != pmwg_pkg::KIND_WRITE) && (req_kind_i != pmwg_pkg::KIND_ERASE);
  endsequence

  // Status clear that no new fault overrides
  sequence s_fault_clear;
    wr_fire_w && wb_sel_i[0] && (wb_adr_i == pmwg_pkg::OFS_STATUS)
    && wb_dat_i[pmwg_pkg::ST_FAULT] && !fault_now_w;
  endsequence

  // Answer comes exactly one cycle after the request
  a_ack_answer: assert property (s_bus_wait |=> wb_ack_o)
    else $error("bus request not acked next cycle");

  // No ack without a live request
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack given without a request");

  // Read data idles at zero between answers
  a_dat_idle: assert property (!wb_ack_o |-> (wb_dat_o == 32'h0))
    else $error("read data not zero outside ack");

  // Readback shows the image in force at the request
  a_cfg_read: assert property (wb_ack_o && $past(!wb_we_i && (wb_adr_i == pmwg_pkg::OFS_CFG))
                               |-> (wb_dat_o == {19'h0, $past(cfg_w)}))
    else $error("configuration readback wrong");

  // Status fields carry the state sampled with the request
  a_status_read: assert property (wb_ack_o && $past(!wb_we_i && (wb_adr_i == pmwg_pkg::OFS_STATUS))
                                  |-> (wb_dat_o[pmwg_pkg::ST_FAULT] == $past(st_reg.fault))
                                  && (wb_dat_o[pmwg_pkg::ST_LDENY] == $past(st_reg.last_deny))
                                  && (wb_dat_o[pmwg_pkg::ST_CNT_LSB +: 8] == $past(st_reg.deny_cnt))
                                  && (wb_dat_o[pmwg_pkg::ST_SEGACT] == $past(seg_act_w)))
    else $error("status read showed wrong fields");

  // Every request gets exactly one verdict, one cycle later
  a_one_verdict: assert property (req_valid_i |=> (req_grant_o != req_deny_o))
    else $error("request got no single verdict");

  // No verdict without a request
  a_no_stray: assert property (!req_valid_i |=> s_no_answer)
    else $error("verdict without a request");

  // Illegal kinds are always refused
  a_odd_kind: assert property (s_odd_kind |=> s_refused)
    else $error("illegal request kind was granted");

  // Refusal count steps by one below saturation
  a_cnt_step: assert property (req_deny_o && ($past(st_reg.deny_cnt) != pmwg_pkg::CNT_MAX)
                               |-> (st_reg.deny_cnt == $past(st_reg.deny_cnt) + 8'h01))
    else $error("denied count did not step");

  // Refusal count holds while no request is taken
  a_cnt_idle: assert property (!req_valid_i |=> $stable(st_reg.deny_cnt))
    else $error("denied count moved without request");

  // A new fault sets the sticky flag
  a_fault_sticky: assert property (fault_now_w |=> st_reg.fault)
    else $error("fault did not set the sticky flag");

  // Clear lands only when no fault is present
  a_fault_clear: assert property (s_fault_clear |=> !st_reg.fault)
    else $error("status clear left the fault flag");

  // Reset request is a single-cycle pulse
  a_reset_pulse: assert property (dev_reset_o |=> !dev_reset_o)
    else $error("device reset longer than one cycle");

  // Injected upset reaches the bank for one cycle only
  a_inject_once: assert property ((st_reg.inject != '0) |=> (st_reg.inject == '0))
    else $error("upset pulse held too long");

endmodule

`default_nettype wire

// ### pmwg_req_model.sv
// Far-side model: flash write/erase sequencer and external programming port.
// Assumes the guard's clock; one request per go pulse, answer one cycle later.
`timescale 1ns/1ps
`default_nettype none

module pmwg_req_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        ext_i,
  input  wire logic [1:0]  kind_i,
  input  wire logic [16:0] addr_i,
  input  wire logic        grant_i,
  output logic             req_valid_o,
  output logic             req_ext_o,
  output logic [1:0]       req_kind_o,
  output logic [16:0]      req_addr_o,
  output var int           changes_o
);
  logic [1:0] pend_reg;

  // =========================================================================
  // Request launch
  initial begin
    req_valid_o = 1'b0;
    req_ext_o   = 1'b0;
    req_kind_o  = 2'h0;
    req_addr_o  = 17'h00000;
    pend_reg    = 2'h0;
    changes_o   = 0;
  end

  // One-cycle strobe; released lines toggle so stale values never look valid
  always @(posedge clk_i) begin
    req_valid_o <= go_i;
    if (go_i) begin
      req_ext_o  <= ext_i;
      req_kind_o <= kind_i;
      req_addr_o <= addr_i;
    end else begin
      req_ext_o  <= ~req_ext_o;
      req_kind_o <= ~req_kind_o;
      req_addr_o <= ~req_addr_o;
    end
  end

  // =========================================================================
  // Memory contents change only on a granted write or erase
  always @(posedge clk_i) begin
    if (req_valid_o) begin
      pend_reg <= req_kind_o;
    end
    if (grant_i === 1'b1 && pend_reg != 2'h0) begin
      changes_o <= changes_o + 1;
    end
  end
endmodule

`default_nettype wire

// ### tb_top.sv
// Testbench for the program memory write guard.
// Assumes pmwg_pkg, pmwg_guard and pmwg_req_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        req_valid_i, req_ext_i, req_grant_o, req_deny_o, dev_reset_o;
  logic [1:0]  req_kind_i;
  logic [16:0] req_addr_i;
  logic        go = 1'b0;
  logic        g_ext = 1'b0;
  logic [1:0]  g_kind = 2'h0;
  logic [16:0] g_addr = 17'h0;
  logic [12:0] cfg;
  logic [31:0] rd;
  logic [7:0]  pgs [6] = '{8'h00, 8'h3f, 8'h40, 8'h41, 8'hfe, 8'hff};
  int          changes, exp_chg, pulses;
  int          err_count = 0;
  int          cmp_count = 0;

  // =========================================================================
  // Clock, design and request model
  always #4 clk_i = ~clk_i;

  pmwg_guard dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_ext_i(req_ext_i),
    .req_kind_i(req_kind_i), .req_addr_i(req_addr_i), .req_grant_o(req_grant_o),
    .req_deny_o(req_deny_o), .dev_reset_o(dev_reset_o));

  pmwg_req_model req_u (.clk_i(clk_i), .go_i(go), .ext_i(g_ext), .kind_i(g_kind), .addr_i(g_addr),
    .grant_i(req_grant_o), .req_valid_o(req_valid_i), .req_ext_o(req_ext_i),
    .req_kind_o(req_kind_i), .req_addr_o(req_addr_i), .changes_o(changes));

  // =========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk(n, 2, "ack latency");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Load configuration words, then let the new value settle
  task automatic set_cfg(input logic [12:0] c);
    wb(1'b1, 8'h00, {19'h0, c}, 4'h3);
    cfg = c;
    repeat (2) @(posedge clk_i);
  endtask

  // Expected verdict from the guard bits and the segment bounds
  function automatic logic exp_ok(input logic [12:0] c, input logic e, input logic [1:0] k,
                                  input logic [7:0] pg);
    logic hit;
    hit = !c[10] && (c[8] ? pg >= c[7:0] : (pg <= c[7:0] || (!c[9] && pg == 8'hff)));
    if (k == 2'h3) return 1'b0;
    if (k == 2'h0) return !(e && c[12]);
    return !((e && c[12]) || (!e && !c[11]) || hit);
  endfunction

  // One request at the first or last word of a page, answer compared
  task automatic req(input logic e, input logic [1:0] k, input logic [7:0] pg);
    logic ok;
    int   n;
    ok = exp_ok(cfg, e, k, pg);
    n = 0;
    go     <= 1'b1;
    g_ext  <= e;
    g_kind <= k;
    g_addr <= {pg, pg[0] ? 9'h1ff : 9'h000};
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_grant_o !== 1'b1 && req_deny_o !== 1'b1 && n < 8);
    chk({30'h0, req_grant_o, req_deny_o}, {30'h0, ok, ~ok}, "verdict");
    if (ok && k != 2'h0) exp_chg++;
  endtask

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // =========================================================================
  // Watchdog
  initial begin
    #200000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  // =========================================================================
  // Test sequence
  initial begin
    exp_chg = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cfg = 13'h0fff;
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rd, 32'h0000_0fff, "cfg reset");
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(rd, 32'h0, "status reset");
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk(rd, 32'h0, "unmapped read");
    // Every kind from both sources under each guard combination
    for (int g = 0; g < 4; g++) begin
      set_cfg({g[1:0], 11'h7ff});
      for (int k = 0; k < 4; k++) begin
        req(1'b0, k[1:0], 8'h10);
        req(1'b1, k[1:0], 8'h10);
      end
    end
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk({31'h0, rd[1]}, 32'h1, "last denied");
    chk({24'h0, rd[15:8]}, 32'h12, "deny count");
    // Segment shapes at the page boundaries
    for (int c = 0; c < 8; c++) begin
      set_cfg({2'b01, c[2:0], 8'h40});
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      chk({31'h0, rd[16]}, {31'h0, ~c[2]}, "segment active");
      for (int i = 0; i < 6; i++) begin
        req(i[0], {~i[0], i[0]}, pgs[i]);
      end
    end
    // Global guards still hold outside a bottom segment
    set_cfg({2'b10, 3'b010, 8'h7f});
    req(1'b0, 2'h1, 8'hc0);
    req(1'b1, 2'h0, 8'hc0);
    req(1'b0, 2'h0, 8'hc0);
    repeat (2) @(posedge clk_i);
    chk(changes, exp_chg, "memory changes");
    // Cell upset: one device reset, sticky fault, cleared after reload
    set_cfg(13'h0fff);
    wb(1'b1, 8'h08, 32'h1, 4'h3);
    pulses = 0;
    repeat (16) begin
      @(posedge clk_i);
      if (dev_reset_o === 1'b1) pulses++;
    end
    chk(pulses, 1, "reset pulses");
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rd, 32'h0000_0ffe, "upset cfg");
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk({31'h0, rd[0]}, 32'h1, "fault flag");
    set_cfg(13'h0fff);
    wb(1'b1, 8'h04, 32'h1, 4'h1);
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk({31'h0, rd[0]}, 32'h0, "fault clear");
    summarize();
  end
endmodule

`default_nettype wire
